// file: hdl/function_handler.sv
// Function-level command interpreter of a serial slave
// How it works
// - Read request carries start address then count, both high byte first; count 1..125.
// - Read answer is function, byte count of twice count, then registers high byte first.
// - Twenty-four sixteen-bit readable registers at addresses 0000 to 0017.
// - Read start above 0017 or end past 0017 gives exception 03.
// - Register zero is the link timeout in tenths; its high byte reads zero.
// - Link timeout register resets to 2, meaning 0.2 seconds.
// - Single write carries address then data, high bytes first; answer echoes request.
// - Writes allowed only to 0000..0005; higher address gives exception 03.
// - Write to register zero needs data high byte zero, else exception 03.
// - Diagnostics act on this module, with a two-byte subfunction then data.
// - Only subfunctions 0000, 0001, 0004; others give exception 03.
// - Query echo returns the whole request unchanged.
// - Restart needs first data byte 00 or FF, else exception 03.
// - Restart echoes normally; in listen-only it stays silent and ends that mode.
// - Force listen-only needs data 0000, else exception 03; enters mode silently.
// - Listen-only answers nothing; only restart or reset brings back normal operation.
// - Listen-only holds the downstream link offline.
// - User function forwards one to eight data bytes downstream as raw bytes.
// - User answer is function byte then 0, 1, 2 or 4 returned bytes.
// - Forwarded length must equal what the downstream command needs, else exception 03.
// - Forwarded bytes are binary values, never translated from text.
// - Exception is function with top bit set then code 01, 03 or 0B.
// - Address zero executes as broadcast with every answer suppressed.
`include "fh_consts.svh"

module function_handler #(
	parameter int DEPTH        = 16,
	parameter int TENTH_CYCLES = `TIMEOUT_UNIT_MS * `CLK_FREQ_KHZ
) (
	// System
	input  wire logic        CLK,
	input  wire logic        RESETN,
	// Request bytes from the framing layer
	input  wire logic        RX_VALID,
	input  wire logic [7:0]  RX_BYTE,
	input  wire logic        RX_LAST,
	output logic             RX_READY,
	// Response bytes to the framing layer
	output logic             TX_VALID,
	output logic [7:0]       TX_BYTE,
	output logic             TX_LAST,
	input  wire logic        TX_READY,
	// Controller register port
	output logic             CTL_RD,
	output logic             CTL_WR,
	output logic [4:0]       CTL_ADDR,
	output logic [15:0]      CTL_WDATA,
	input  wire logic [15:0] CTL_RDATA,
	input  wire logic        CTL_ACK,
	// Downstream command link
	output logic             DS_ONLINE,
	output logic             DS_CMD_VALID,
	output logic [3:0]       DS_CMD_LEN,
	output logic [63:0]      DS_CMD_DATA,
	input  wire logic [3:0]  DS_NEED_LEN,
	input  wire logic        DS_RSP_VALID,
	input  wire logic        DS_RSP_ERR,
	input  wire logic [2:0]  DS_RSP_LEN,
	input  wire logic [31:0] DS_RSP_DATA,
	// Status
	output logic             LISTEN_ONLY
);

	localparam int IW = $clog2(DEPTH);

	// ----------------------------------------
	// State
	// ----------------------------------------
	fh_pkg::state_t    state_r;
	fh_pkg::rsp_kind_t kind_r;
	fh_pkg::hdr_t      hdr;
	logic [4:0]        cnt_r;
	logic              ovf_r;
	logic [7:0]        timeout_r;
	logic              listen_r;
	logic              listen_clr_r;
	logic [7:0]        tx_idx_r;
	logic [7:0]        tx_len_r;
	logic [7:0]        exc_r;
	logic [7:0]        bcount_r;
	logic [4:0]        rd_addr_r;
	logic [15:0]       val_r;
	logic [31:0]       rsp_r;
	logic [7:0]        tmo_cnt_r;
	logic [7:0]        echo_byte;
	logic [7:0]        tx_nxt;
	logic              rx_take;
	logic              tick;
	logic              quiet;
	logic              rd_bad;
	logic              wr_bad;
	logic              len6;
	logic [16:0]       rd_end;
	logic [15:0]       start;
	logic [15:0]       count;
	logic [3:0]        link_len;

	assign rx_take = RX_VALID && RX_READY;

	req_store #(.DEPTH(DEPTH)) u_store (
		.clk     (CLK),
		.wr_en   (rx_take && !ovf_r),
		.wr_idx  (cnt_r[IW-1:0]),
		.wr_byte (RX_BYTE),
		.rd_idx  (tx_idx_r[IW-1:0]),
		.rd_byte (echo_byte),
		.hdr     (hdr)
	);

	tenth_tick #(.CYCLES(TENTH_CYCLES)) u_tick (
		.clk    (CLK),
		.resetn (RESETN),
		.run    (state_r == fh_pkg::S_DS_WAIT),
		.tick   (tick)
	);

	// ----------------------------------------
	// Request checks
	// ----------------------------------------
	always_comb begin
		start    = {hdr.b2, hdr.b3};
		count    = {hdr.b4, hdr.b5};
		rd_end   = {1'b0, start} + {1'b0, count} - 17'h00001;
		rd_bad   = (count == 16'h0000) || (count > `MAX_RD_COUNT) ||
		           (start > `LAST_REG) || (rd_end > {1'b0, `LAST_REG});
		wr_bad   = (start > `LAST_WR_REG) ||
		           ((start == `TIMEOUT_REG) && (hdr.b4 != 8'h00));
		len6     = (cnt_r == `FIXED_ADU_LEN) && !ovf_r;
		link_len = 4'(cnt_r - `HDR_LEN);
		quiet    = (hdr.addr == `BROADCAST_ADDR) || listen_r;
	end

	// ----------------------------------------
	// Next response byte
	// ----------------------------------------
	always_comb begin
		tx_nxt = hdr.addr;
		unique case (kind_r)
			fh_pkg::K_ECHO: tx_nxt = echo_byte;
			fh_pkg::K_EXC: begin
				if (tx_idx_r == 8'h01) begin
					tx_nxt = hdr.func | `FN_EXC_FLAG;
				end else if (tx_idx_r == 8'h02) begin
					tx_nxt = exc_r;
				end
			end
			fh_pkg::K_READ: begin
				if (tx_idx_r == 8'h01) begin
					tx_nxt = hdr.func;
				end else if (tx_idx_r == 8'h02) begin
					tx_nxt = bcount_r;
				end else if (tx_idx_r > 8'h02) begin
					tx_nxt = tx_idx_r[0] ? val_r[15:8] : val_r[7:0];
				end
			end
			fh_pkg::K_LINK: begin
				if (tx_idx_r == 8'h01) begin
					tx_nxt = hdr.func;
				end else if (tx_idx_r > 8'h01) begin
					tx_nxt = rsp_r[{tx_idx_r[1:0] - 2'h2, 3'h0} +: 8];
				end
			end
		endcase
	end

	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			RX_READY <= 1'b1;
		end else if (rx_take && RX_LAST) begin
			RX_READY <= 1'b0;
		end else if (state_r == fh_pkg::S_DONE) begin
			RX_READY <= 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN || state_r == fh_pkg::S_DONE) begin
			cnt_r       <= '0;
			ovf_r       <= 1'b0;
			DS_CMD_DATA <= '0;
		end else if (rx_take && !ovf_r) begin
			cnt_r <= cnt_r + 1'b1;
			ovf_r <= (cnt_r == 5'(DEPTH - 1));
			if (cnt_r >= `HDR_LEN && cnt_r < `HDR_LEN + 5'(`MAX_LINK_LEN)) begin
				DS_CMD_DATA[{cnt_r[2:0] - 3'h2, 3'h0} +: 8] <= RX_BYTE;
			end
		end
	end

	// ----------------------------------------
	// Listen-only mode and link status
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			DS_ONLINE   <= 1'b0;
			LISTEN_ONLY <= 1'b0;
		end else begin
			DS_ONLINE   <= !listen_r;
			LISTEN_ONLY <= listen_r;
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	task automatic answer(input fh_pkg::rsp_kind_t k, input logic [7:0] len);
		kind_r   <= k;
		tx_len_r <= len;
		tx_idx_r <= '0;
		state_r  <= quiet ? fh_pkg::S_DONE : fh_pkg::S_TX;
	endtask

	task automatic fail(input logic [7:0] code);
		exc_r <= code;
		answer(fh_pkg::K_EXC, `EXC_LEN);
	endtask

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state_r      <= fh_pkg::S_RX;
			kind_r       <= fh_pkg::K_ECHO;
			timeout_r    <= `TIMEOUT_RESET;
			listen_r     <= 1'b0;
			listen_clr_r <= 1'b0;
			tx_idx_r     <= '0;
			tx_len_r     <= '0;
			exc_r        <= '0;
			bcount_r     <= '0;
			rd_addr_r    <= '0;
			val_r        <= '0;
			rsp_r        <= '0;
			tmo_cnt_r    <= '0;
			TX_VALID     <= 1'b0;
			TX_BYTE      <= '0;
			TX_LAST      <= 1'b0;
			CTL_RD       <= 1'b0;
			CTL_WR       <= 1'b0;
			CTL_ADDR     <= '0;
			CTL_WDATA    <= '0;
			DS_CMD_VALID <= 1'b0;
			DS_CMD_LEN   <= '0;
		end else begin
			CTL_RD       <= 1'b0;
			CTL_WR       <= 1'b0;
			DS_CMD_VALID <= 1'b0;
			unique case (state_r)
				fh_pkg::S_RX: begin
					if (rx_take && RX_LAST) begin
						state_r <= fh_pkg::S_EXEC;
					end
				end
				fh_pkg::S_EXEC: begin
					if (cnt_r < `HDR_LEN) begin
						state_r <= fh_pkg::S_DONE;
					end else if (listen_r) begin
						// Only a well-formed restart is acted on here
						if (hdr.func == `FN_DIAG && len6 && {hdr.b2, hdr.b3} == `SUB_RESTART &&
						    (hdr.b4 == `RESTART_KEEP || hdr.b4 == `RESTART_CLEAR)) begin
							listen_clr_r <= 1'b1;
						end
						state_r <= fh_pkg::S_DONE;
					end else begin
						unique case (hdr.func)
							`FN_READ_REGS: begin
								if (!len6 || rd_bad) begin
									fail(`EXC_BAD_DATA);
								end else begin
									rd_addr_r <= start[4:0];
									bcount_r  <= {count[6:0], 1'b0};
									answer(fh_pkg::K_READ, `READ_HDR_LEN + {count[6:0], 1'b0});
								end
							end
							`FN_WRITE_REG: begin
								if (!len6 || wr_bad) begin
									fail(`EXC_BAD_DATA);
								end else if (start == `TIMEOUT_REG) begin
									timeout_r <= hdr.b5;
									answer(fh_pkg::K_ECHO, 8'(cnt_r));
								end else begin
									CTL_WR    <= 1'b1;
									CTL_ADDR  <= start[4:0];
									CTL_WDATA <= count;
									state_r   <= fh_pkg::S_WR_WAIT;
								end
							end
							`FN_DIAG: begin
								if (!len6) begin
									fail(`EXC_BAD_DATA);
								end else begin
									unique case ({hdr.b2, hdr.b3})
										`SUB_ECHO: answer(fh_pkg::K_ECHO, 8'(cnt_r));
										`SUB_RESTART: begin
											if (hdr.b4 == `RESTART_KEEP ||
											    hdr.b4 == `RESTART_CLEAR) begin
												answer(fh_pkg::K_ECHO, 8'(cnt_r));
											end else begin
												fail(`EXC_BAD_DATA);
											end
										end
										`SUB_LISTEN: begin
											if ({hdr.b4, hdr.b5} == `LISTEN_DATA) begin
												listen_r <= 1'b1;
												state_r  <= fh_pkg::S_DONE;
											end else begin
												fail(`EXC_BAD_DATA);
											end
										end
										default: fail(`EXC_BAD_DATA);
									endcase
								end
							end
							`FN_USER_LINK: begin
								if (ovf_r || link_len < `MIN_LINK_LEN ||
								    link_len > `MAX_LINK_LEN || link_len != DS_NEED_LEN) begin
									fail(`EXC_BAD_DATA);
								end else begin
									DS_CMD_VALID <= 1'b1;
									DS_CMD_LEN   <= link_len;
									tmo_cnt_r    <= '0;
									state_r      <= fh_pkg::S_DS_WAIT;
								end
							end
							default: fail(`EXC_BAD_FUNC);
						endcase
					end
				end
				fh_pkg::S_RD_FETCH: begin
					rd_addr_r <= rd_addr_r + 1'b1;
					if (rd_addr_r == 5'(`TIMEOUT_REG)) begin
						val_r   <= {8'h00, timeout_r};
						state_r <= fh_pkg::S_TX;
					end else begin
						CTL_RD   <= 1'b1;
						CTL_ADDR <= rd_addr_r;
						state_r  <= fh_pkg::S_RD_WAIT;
					end
				end
				fh_pkg::S_RD_WAIT: begin
					if (CTL_ACK) begin
						val_r   <= CTL_RDATA;
						state_r <= fh_pkg::S_TX;
					end
				end
				fh_pkg::S_WR_WAIT: begin
					if (CTL_ACK) begin
						answer(fh_pkg::K_ECHO, 8'(cnt_r));
					end
				end
				fh_pkg::S_DS_WAIT: begin
					if (tick) begin
						tmo_cnt_r <= tmo_cnt_r + 1'b1;
					end
					if (DS_RSP_VALID) begin
						if (DS_RSP_ERR) begin
							fail(`EXC_LINK_FAIL);
						end else begin
							rsp_r <= DS_RSP_DATA;
							answer(fh_pkg::K_LINK, 8'(`HDR_LEN) + 8'(DS_RSP_LEN));
						end
					end else if (tmo_cnt_r >= timeout_r) begin
						fail(`EXC_LINK_FAIL);
					end
				end
				fh_pkg::S_TX: begin
					if (!TX_VALID) begin
						TX_VALID <= 1'b1;
						TX_BYTE  <= tx_nxt;
						TX_LAST  <= (tx_idx_r == tx_len_r - 8'h01);
					end else if (TX_READY) begin
						TX_VALID <= 1'b0;
						TX_LAST  <= 1'b0;
						tx_idx_r <= tx_idx_r + 8'h01;
						if (TX_LAST) begin
							state_r <= fh_pkg::S_DONE;
						end else if (kind_r == fh_pkg::K_READ && tx_idx_r >= 8'h02 &&
						             !tx_idx_r[0]) begin
							state_r <= fh_pkg::S_RD_FETCH;
						end
					end
				end
				fh_pkg::S_DONE: begin
					if (listen_clr_r) begin
						listen_r <= 1'b0;
					end
					listen_clr_r <= 1'b0;
					state_r      <= fh_pkg::S_RX;
				end
				default: state_r <= fh_pkg::S_DONE;
			endcase
		end
	end

endmodule // function_handler

// file: hdl/fh_consts.svh
// Named constants of the function handler
`ifndef FH_CONSTS_SVH
`define FH_CONSTS_SVH

// ----------------------------------------
// Function and exception codes
// ----------------------------------------
`define FN_READ_REGS    8'h03
`define FN_WRITE_REG    8'h06
`define FN_DIAG         8'h08
`define FN_USER_LINK    8'h41
`define FN_EXC_FLAG     8'h80
`define EXC_BAD_FUNC    8'h01
`define EXC_BAD_DATA    8'h03
`define EXC_LINK_FAIL   8'h0b

// ----------------------------------------
// Diagnostic subfunctions and data values
// ----------------------------------------
`define SUB_ECHO        16'h0000
`define SUB_RESTART     16'h0001
`define SUB_LISTEN      16'h0004
`define RESTART_KEEP    8'h00
`define RESTART_CLEAR   8'hff
`define LISTEN_DATA     16'h0000

// ----------------------------------------
// Register space and request layout
// ----------------------------------------
`define LAST_REG        16'h0017
`define LAST_WR_REG     16'h0005
`define TIMEOUT_REG     16'h0000
`define TIMEOUT_RESET   8'h02
`define MAX_RD_COUNT    16'h007d
`define FIXED_ADU_LEN   5'h06
`define HDR_LEN         5'h02
`define MIN_LINK_LEN    4'h1
`define MAX_LINK_LEN    4'h8
`define BROADCAST_ADDR  8'h00
`define READ_HDR_LEN    8'h03
`define EXC_LEN         8'h03

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_FREQ_KHZ    40000
`define TIMEOUT_UNIT_MS 100

`endif

// file: hdl/fh_pkg.sv
// Types shared by the function handler modules
package fh_pkg;

	// ----------------------------------------
	// Sequencer states and answer kinds
	// ----------------------------------------
	typedef enum logic [3:0] {
		S_RX, S_EXEC, S_RD_FETCH, S_RD_WAIT, S_WR_WAIT, S_DS_WAIT, S_TX, S_DONE
	} state_t;

	typedef enum logic [1:0] {K_ECHO, K_EXC, K_READ, K_LINK} rsp_kind_t;

	// ----------------------------------------
	// First six bytes of a request
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] func;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [7:0] b4;
		logic [7:0] b5;
	} hdr_t;

endpackage

// file: hdl/req_store.sv
// Byte store for one received request
module req_store #(
	parameter int DEPTH = 16
) (
	// Clock
	input  wire logic                     clk,
	// Write side
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_idx,
	input  wire logic [7:0]               wr_byte,
	// Read side
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx,
	output logic      [7:0]               rd_byte,
	output fh_pkg::hdr_t                  hdr
);

	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_byte;
		end
	end

	assign rd_byte = mem[rd_idx];
	assign hdr     = {mem[0], mem[1], mem[2], mem[3], mem[4], mem[5]};

endmodule // req_store

// file: hdl/tenth_tick.sv
// Divider giving one enable pulse per timeout unit
module tenth_tick #(
	parameter int CYCLES = 4000000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// Control
	input  wire logic run,
	output logic      tick
);

	localparam int W = $clog2(CYCLES);

	logic [W-1:0] cnt_r;

	// Restarts whenever not running so every wait gets whole units
	always_ff @(posedge clk) begin
		if (!resetn || !run) begin
			cnt_r <= '0;
			tick  <= 1'b0;
		end else if (cnt_r == W'(CYCLES - 1)) begin
			cnt_r <= '0;
			tick  <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick  <= 1'b0;
		end
	end

endmodule // tenth_tick

// file: testbench/far_side_model.sv
// Behavioural controller register port and downstream slave
module far_side_model (
	// Clock
	input wire logic	clk,
	// Controller register port
	input wire logic	ctl_rd,
	input wire logic	ctl_wr,
	input wire logic [4:0]	ctl_addr,
	input wire logic [15:0]	ctl_wdata,
	output logic [15:0]	ctl_rdata,
	output logic	ctl_ack,
	// Downstream link
	input wire logic	ds_online,
	input wire logic	ds_cmd_valid,
	input wire logic [63:0]	ds_cmd_data,
	output logic [3:0]	ds_need_len,
	output logic	ds_rsp_valid,
	output logic	ds_rsp_err,
	output logic [2:0]	ds_rsp_len,
	output logic [31:0]	ds_rsp_data,
	// Scenario controls
	input wire logic [2:0]	rsp_len,
	input wire logic	rsp_err,
	input wire logic	mute
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0]	regs [0:31];
	logic [15:0]	dat_r;
	logic [4:0]	a_r;
	logic [2:0]	cnt_r;
	logic [1:0]	dcnt_r;
	initial begin
		cnt_r = 3'h0;
		dcnt_r = 2'h0;
		ctl_ack = 1'b0;
		ds_rsp_valid = 1'b0;
		for (int i = 0; i < 32; i++) regs[i] = 16'hc000 | 16'(i);
	end
	// Odd addresses answer promptly, even ones slowly
	always @(posedge clk) begin
		ctl_ack <= (cnt_r == 3'h1);
		cnt_r <= (cnt_r != 3'h0) ? cnt_r - 3'h1 : 3'h0;
		if (ctl_rd || ctl_wr) begin
			cnt_r <= ctl_addr[0] ? 3'h1 : 3'h4;
			a_r <= ctl_addr;
		end
		if (ctl_wr)
			regs[ctl_addr] <= ctl_wdata;
		if (cnt_r == 3'h1)
			dat_r <= regs[a_r];
	end
	// Released data shows the inverse of the last value
	assign ctl_rdata = ctl_ack ? dat_r : ~dat_r;
	assign ds_need_len = {1'b0, ds_cmd_data[2:0]} + 4'h1;
	// An offline or muted link never answers
	always @(posedge clk) begin
		ds_rsp_valid <= (dcnt_r == 2'h1);
		dcnt_r <= (dcnt_r != 2'h0) ? dcnt_r - 2'h1 : 2'h0;
		if (ds_cmd_valid && ds_online && !mute)
			dcnt_r <= 2'h3;
	end
	assign ds_rsp_err = ds_rsp_valid ? rsp_err : 1'b0;
	assign ds_rsp_len = ds_rsp_valid ? rsp_len : ~rsp_len;
	assign ds_rsp_data = ds_rsp_valid ? 32'h44332211 : 32'hbbccddee;
endmodule // far_side_model

// file: testbench/fh_properties.sv
// Port checker of the function handler
module fh_properties (
	// Clock and reset
	input wire logic	CLK,
	input wire logic	RESETN,
	// Request and response streams
	input wire logic	RX_VALID,
	input wire logic	RX_LAST,
	input wire logic	RX_READY,
	input wire logic	TX_VALID,
	input wire logic [7:0]	TX_BYTE,
	input wire logic	TX_READY,
	// Controller and downstream
	input wire logic	CTL_RD,
	input wire logic	CTL_WR,
	input wire logic [4:0]	CTL_ADDR,
	input wire logic	DS_ONLINE,
	input wire logic	DS_CMD_VALID,
	input wire logic [3:0]	DS_CMD_LEN,
	input wire logic	LISTEN_ONLY
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	a_listen_offline: assert property (LISTEN_ONLY |-> !DS_ONLINE)
		else $error("link online in listen-only");
	a_listen_silent: assert property (LISTEN_ONLY |-> !TX_VALID)
		else $error("response in listen-only");
	a_rd_range: assert property (CTL_RD |-> CTL_ADDR inside {[1:23]})
		else $error("controller read address out of range");
	a_wr_range: assert property (CTL_WR |-> CTL_ADDR inside {[1:5]})
		else $error("controller write address out of range");
	a_cmd_len: assert property (DS_CMD_VALID |-> DS_CMD_LEN inside {[1:8]} && DS_ONLINE)
		else $error("bad downstream command");
	a_tx_hold: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_BYTE))
		else $error("response byte not held");
	a_rx_block: assert property (RX_VALID && RX_READY && RX_LAST |=> !RX_READY && !TX_VALID)
		else $error("request taken during processing");
	a_pulse_once: assert property (CTL_RD |=> !CTL_RD && !CTL_WR)
		else $error("controller pulse too long");
	c_exception: cover property (TX_VALID && TX_READY && TX_BYTE == 8'h83);
	c_listen: cover property ($rose(LISTEN_ONLY));
	c_command: cover property (DS_CMD_VALID);
endmodule // fh_properties

bind function_handler fh_properties u_props (
	.CLK, .RESETN, .RX_VALID, .RX_LAST, .RX_READY, .TX_VALID, .TX_BYTE, .TX_READY,
	.CTL_RD, .CTL_WR, .CTL_ADDR, .DS_ONLINE, .DS_CMD_VALID, .DS_CMD_LEN, .LISTEN_ONLY
);

// file: testbench/tb_top.sv
// Self-checking bench of the function handler
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic	clk, resetn, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
	logic	ctl_rd, ctl_wr, ctl_ack, ds_online, ds_cmd_valid, ds_rsp_valid, ds_rsp_err;
	logic	listen_only, rsp_err, mute;
	logic [7:0]	rx_byte, tx_byte;
	logic [4:0]	ctl_addr;
	logic [15:0]	ctl_wdata, ctl_rdata;
	logic [3:0]	ds_cmd_len, ds_need_len, len_seen;
	logic [63:0]	ds_cmd_data, cmd_seen;
	logic [2:0]	ds_rsp_len, rsp_len;
	logic [31:0]	ds_rsp_data;
	int	num_errors = 0;
	int	n_checks = 0;

	function_handler #(.TENTH_CYCLES(20)) dut (
		.CLK(clk), .RESETN(resetn), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
		.RX_LAST(rx_last), .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_BYTE(tx_byte),
		.TX_LAST(tx_last), .TX_READY(tx_ready), .CTL_RD(ctl_rd), .CTL_WR(ctl_wr),
		.CTL_ADDR(ctl_addr), .CTL_WDATA(ctl_wdata), .CTL_RDATA(ctl_rdata), .CTL_ACK(ctl_ack),
		.DS_ONLINE(ds_online), .DS_CMD_VALID(ds_cmd_valid), .DS_CMD_LEN(ds_cmd_len),
		.DS_CMD_DATA(ds_cmd_data), .DS_NEED_LEN(ds_need_len), .DS_RSP_VALID(ds_rsp_valid),
		.DS_RSP_ERR(ds_rsp_err), .DS_RSP_LEN(ds_rsp_len), .DS_RSP_DATA(ds_rsp_data),
		.LISTEN_ONLY(listen_only)
	);
	far_side_model far (.clk, .ctl_rd, .ctl_wr, .ctl_addr, .ctl_wdata, .ctl_rdata, .ctl_ack,
		.ds_online, .ds_cmd_valid, .ds_cmd_data, .ds_need_len, .ds_rsp_valid, .ds_rsp_err,
		.ds_rsp_len, .ds_rsp_data, .rsp_len, .rsp_err, .mute);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Sink stalls every other cycle
	always @(posedge clk) tx_ready <= #2 ~tx_ready;
	always @(posedge clk) if (ds_cmd_valid) {len_seen, cmd_seen} <= {ds_cmd_len, ds_cmd_data};

	task automatic chk(input string nm, input logic [63:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// ----------------------------------------
	// One request, then its response or silence
	// ----------------------------------------
	task automatic x(input logic [95:0] q, input int nq, input logic [63:0] e, input int ne);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		for (int i = nq - 1; i >= 0; i--) begin
			#2;
			rx_valid = 1'b1;
			rx_byte = q[8*i+:8];
			rx_last = (i == 0);
			do @(posedge clk); while (rx_ready !== 1'b1);
		end
		#2;
		rx_valid = 1'b0;
		rx_last = 1'b0;
		for (int i = ne - 1; i >= 0; i--) begin
			do @(posedge clk); while (!(tx_valid === 1'b1 && tx_ready === 1'b1));
			chk("tx byte", tx_byte, e[8*i+:8]);
			chk("tx last", tx_last, i == 0);
		end
		if (ne == 0) begin
			repeat (30) begin
				@(posedge clk);
				seen |= (tx_valid !== 1'b0);
			end
			chk("silence", seen, 0);
		end
	endtask

	task automatic summarize();
		if (num_errors == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial begin
		#(20000 * 25);
		num_errors++;
		summarize();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		resetn = 1'b0; rx_valid = 1'b0; rx_byte = 8'h00; rx_last = 1'b0; tx_ready = 1'b0;
		rsp_len = 3'h0; rsp_err = 1'b0; mute = 1'b0;
		repeat (2) @(posedge clk);
		#2 resetn = 1'b1;
		x(48'h110300000001, 6, 40'h1103020002, 5);
		x(48'h110300160002, 6, 56'h110304c016c017, 7);
		x(48'h110300170002, 6, 24'h118303, 3);
		x(48'h110300180001, 6, 24'h118303, 3);
		x(48'h110300000000, 6, 24'h118303, 3);
		x(48'h110600000005, 6, 48'h110600000005, 6);
		x(48'h110600000105, 6, 24'h118603, 3);
		x(48'h110300000001, 6, 40'h1103020005, 5);
		x(48'h110600051234, 6, 48'h110600051234, 6);
		x(48'h110300050001, 6, 40'h1103021234, 5);
		x(48'h110600060001, 6, 24'h118603, 3);
		x(48'h110500000001, 6, 24'h118501, 3);
		x(48'h11080000a55a, 6, 48'h11080000a55a, 6);
		x(48'h110800020000, 6, 24'h118803, 3);
		x(48'h11080001ff00, 6, 48'h11080001ff00, 6);
		x(48'h110800010000, 6, 48'h110800010000, 6);
		x(48'h110800011200, 6, 24'h118803, 3);
		x(48'h110800040001, 6, 24'h118803, 3);
		x(48'h110800040000, 6, 0, 0);
		chk("listen", listen_only, 1);
		chk("online", ds_online, 0);
		x(48'h110300000001, 6, 0, 0);
		x(48'h11080001ff00, 6, 0, 0);
		chk("listen", listen_only, 0);
		chk("online", ds_online, 1);
		x(48'h110300000001, 6, 40'h1103020005, 5);
		for (int k = 0; k < 4; k++) begin
			rsp_len = (k == 3) ? 3'h4 : 3'(k);
			x(40'h114102aabb, 5, 64'({16'h1141, 32'h11223344}) >> (8 * (4 - rsp_len)),
				2 + rsp_len);
			chk("command", cmd_seen[23:0], 24'hbbaa02);
			chk("length", len_seen, 3);
		end
		rsp_len = 3'h0;
		x(80'h11410701020304050607, 10, 16'h1141, 2);
		chk("command", cmd_seen, 64'h0706050403020107);
		chk("length", len_seen, 8);
		x(24'h114100, 3, 16'h1141, 2);
		x(32'h114102aa, 4, 24'h11c103, 3);
		rsp_err = 1'b1;
		x(40'h114102aabb, 5, 24'h11c10b, 3);
		rsp_err = 1'b0;
		mute = 1'b1;
		x(40'h114102aabb, 5, 24'h11c10b, 3);
		mute = 1'b0;
		x(48'h000600060001, 6, 0, 0);
		x(48'h000600000007, 6, 0, 0);
		x(48'h110300000001, 6, 40'h1103020007, 5);
		summarize();
	end
endmodule // tb_top
